// ==== hdl/acoc_top.sv ====
`timescale 1ns/1ps
`include "acoc_map.svh"
//Contract
//- serial internal-clock mode drives a frame sync bracketing the data word
//- polarity input low: frame sync high while serial data valid
//- polarity input high: frame sync low while serial data valid
//- external clock: read unfinished at next conversion end drops data, pulses error
//- parallel mode: error pin carries result bit 11
//- result bits 12 to 15 are outputs in both modes
//- busy rises at start, falls once result is latched
//- output bus enabled only while chip select and read both low
//- chip select gates the external serial clock
//- reset input high aborts conversion and resets device
//- power-down lets conversion finish, then inhibits conversions
//- start high at acquisition end: wait for next falling edge
//- start low at acquisition end: convert at once
//- reference disable low keeps internal reference on, high turns it off
//- buffer disable low selects buffer, high switches it off
//- serial result goes out most significant bit first
//- clock source select sets serial clock pin direction
module acoc_top import acoc_pkg::*; #(
    parameter int ACQ_CYC   = `ACOC_ACQ_CYC,
    parameter int CONV_CYC  = `ACOC_CONV_CYC,
    parameter int SCLK_HALF = `ACOC_SCLK_HALF
) (
    // clocks and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        sclk_ext,
    // host control pins
    input  wire logic        conversion_start_n,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        reset_pin,
    input  wire logic        low_power_request,
    input  wire logic        serial_parallel_select,
    input  wire logic        clock_source_select,
    input  wire logic        frame_sync_polarity,
    input  wire logic        internal_ref_disable,
    input  wire logic        ref_buffer_disable,
    // converter core
    input  wire logic [15:0] adc_code,
    // data pins
    output logic      [15:0] data_pins,
    output logic      [15:0] data_oe,
    // status and analog controls
    output logic             busy,
    output logic             sample_hold,
    output logic             low_power_state,
    output logic             ref_enable,
    output logic             ref_buffer_enable
);
    if (SCLK_HALF < 1 || SCLK_HALF > 255) begin : g_bad
        $error("acoc_top: SCLK_HALF out of range");
    end
    localparam logic [7:0] HALF_LD = 8'(SCLK_HALF - 1);

    acoc_if ifc ();

    // ************************
    // pin synchronisers
    // ************************
    logic [12:0] s1_r, s2_r;
    logic        cnv_d_r, st_d_r, dn_d_r;
    logic        cnv_s, cs_s, rd_s, rstp_s, pd_s, ser_s, ext_s;
    logic        inv_s, refd_s, bufd_s, st_s, dn_s, lsdo_s;
    logic        bus_en;

    always_ff @(posedge clock) begin
        s1_r    <= {ifc.serial_data_out, ifc.done_tgl, ifc.start_tgl, ref_buffer_disable,
                    internal_ref_disable, frame_sync_polarity, clock_source_select,
                    serial_parallel_select, low_power_request, reset_pin, rd_n, cs_n,
                    conversion_start_n};
        s2_r    <= s1_r;
        cnv_d_r <= s2_r[0];
        st_d_r  <= s2_r[10];
        dn_d_r  <= s2_r[11];
    end

    assign cnv_s  = s2_r[0];
    assign cs_s   = s2_r[1];
    assign rd_s   = s2_r[2];
    assign rstp_s = s2_r[3];
    assign pd_s   = s2_r[4];
    assign ser_s  = s2_r[5];
    assign ext_s  = s2_r[6];
    assign inv_s  = s2_r[7];
    assign refd_s = s2_r[8];
    assign bufd_s = s2_r[9];
    assign st_s   = s2_r[10];
    assign dn_s   = s2_r[11];
    assign lsdo_s = s2_r[12];
    assign bus_en = !cs_s && !rd_s;

    // ************************
    // conversion control
    // ************************
    assign ifc.cnv_low  = !cnv_s;
    assign ifc.cnv_fall = cnv_d_r && !cnv_s;
    assign ifc.pd       = pd_s;
    assign ifc.abort    = rstp_s;
    assign ifc.code     = adc_code;
    assign ifc.cs_n     = cs_n;

    acoc_conv #(
        .ACQ_CYC  (ACQ_CYC),
        .CONV_CYC (CONV_CYC)
    ) u_conv (
        .clock (clock),
        .rst_b (rst_b),
        .cv    (ifc.conv)
    );

    // ************************
    // internal-clock serial read
    // ************************
    acoc_word_t ish_r, ish_nxt;
    logic [4:0] icnt_r, icnt_nxt;
    logic [7:0] idiv_r, idiv_nxt;
    logic       ia_r, ia_nxt;
    logic       isck_r, isck_nxt;
    logic       sent_r, sent_nxt;
    logic       have_r, have_nxt;
    logic       i_start;

    assign i_start = ser_s && !ext_s && bus_en && !ia_r && !sent_r && have_r && !ifc.busy;

    always_comb begin
        ish_nxt  = ish_r;
        icnt_nxt = icnt_r;
        idiv_nxt = idiv_r;
        ia_nxt   = ia_r;
        isck_nxt = isck_r;
        sent_nxt = sent_r;
        have_nxt = have_r || ifc.latched;
        if (i_start) begin
            ish_nxt  = ifc.result;
            icnt_nxt = `ACOC_WORD_BITS;
            idiv_nxt = HALF_LD;
            isck_nxt = 1'b0;
            ia_nxt   = 1'b1;
        end else if (ia_r) begin
            // losing the bus or the mode ends the frame early
            if (!bus_en || !ser_s || ext_s) begin
                ia_nxt   = 1'b0;
                isck_nxt = 1'b0;
            end else if (idiv_r != 8'h00) begin
                idiv_nxt = idiv_r - 8'h01;
            end else begin
                idiv_nxt = HALF_LD;
                isck_nxt = ~isck_r;
                if (isck_r) begin
                    ish_nxt  = {ish_r[14:0], 1'b0};
                    icnt_nxt = icnt_r - 5'h01;
                    if (icnt_r == 5'h01) begin
                        ia_nxt   = 1'b0;
                        sent_nxt = 1'b1;
                    end
                end
            end
        end
        if (ifc.latched) begin
            sent_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || rstp_s) begin
            ish_r  <= `ACOC_RES_RST;
            icnt_r <= 5'h00;
            idiv_r <= 8'h00;
            ia_r   <= 1'b0;
            isck_r <= 1'b0;
            sent_r <= 1'b0;
            have_r <= 1'b0;
        end else begin
            ish_r  <= ish_nxt;
            icnt_r <= icnt_nxt;
            idiv_r <= idiv_nxt;
            ia_r   <= ia_nxt;
            isck_r <= isck_nxt;
            sent_r <= sent_nxt;
            have_r <= have_nxt;
        end
    end

    // ************************
    // external-clock link and read error
    // ************************
    logic       ldt_r, ldt_nxt;
    acoc_word_t ldw_r, ldw_nxt;
    logic       lrst_r;
    logic       pend_r, pend_nxt;
    logic [2:0] errc_r, errc_nxt;
    logic       err_set;

    assign err_set = ifc.latched && pend_r && ser_s && ext_s;

    always_comb begin
        ldt_nxt  = ldt_r;
        ldw_nxt  = ldw_r;
        pend_nxt = pend_r;
        errc_nxt = errc_r;
        if (ifc.latched) begin
            ldt_nxt  = ~ldt_r;
            ldw_nxt  = ifc.result;
        end
        // a read seen starting as a result lands still counts as pending
        if (dn_s != dn_d_r || ifc.latched) begin
            pend_nxt = 1'b0;
        end
        if (st_s != st_d_r) begin
            pend_nxt = 1'b1;
        end
        if (err_set) begin
            errc_nxt = `ACOC_ERR_CYC;
        end else if (errc_r != 3'h0) begin
            errc_nxt = errc_r - 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        lrst_r <= !rst_b || rstp_s;
        if (!rst_b || rstp_s) begin
            ldt_r  <= 1'b0;
            ldw_r  <= `ACOC_RES_RST;
            pend_r <= 1'b0;
            errc_r <= 3'h0;
        end else begin
            ldt_r  <= ldt_nxt;
            ldw_r  <= ldw_nxt;
            pend_r <= pend_nxt;
            errc_r <= errc_nxt;
        end
    end

    assign ifc.load_tgl  = ldt_r;
    assign ifc.load_word = ldw_r;
    assign ifc.link_rst  = lrst_r;

    acoc_link u_link (
        .sclk_ext (sclk_ext),
        .lk       (ifc.link)
    );

    // ************************
    // pin drivers
    // ************************
    logic [15:0] pin_o_r, pin_o_nxt;
    logic [15:0] pin_oe_r, pin_oe_nxt;
    logic        ref_r, buf_r, lowp_r, hold_r;

    always_comb begin
        pin_o_nxt  = 16'h0000;
        pin_oe_nxt = 16'h0000;
        if (!ser_s) begin
            pin_o_nxt  = ifc.result;
            pin_oe_nxt = {16{bus_en}};
        end else begin
            pin_o_nxt[`ACOC_PIN_SDO]  = ext_s ? lsdo_s : ish_r[15];
            pin_oe_nxt[`ACOC_PIN_SDO] = bus_en;
            pin_o_nxt[`ACOC_PIN_SCLK]  = isck_r;
            pin_oe_nxt[`ACOC_PIN_SCLK] = !ext_s;
            // frame sync idles at the inactive level between frames
            pin_o_nxt[`ACOC_PIN_SYNC]  = ia_r ? !inv_s : inv_s;
            pin_oe_nxt[`ACOC_PIN_SYNC] = !ext_s;
            pin_o_nxt[`ACOC_PIN_ERR]  = (errc_r != 3'h0);
            pin_oe_nxt[`ACOC_PIN_ERR] = ext_s;
            pin_o_nxt[15:12]  = ifc.result[15:12];
            pin_oe_nxt[15:12] = {4{bus_en}};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_o_r  <= 16'h0000;
            pin_oe_r <= 16'h0000;
            ref_r    <= 1'b0;
            buf_r    <= 1'b0;
            lowp_r   <= 1'b0;
            hold_r   <= 1'b0;
        end else begin
            pin_o_r  <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
            ref_r    <= !refd_s;
            buf_r    <= !bufd_s;
            lowp_r   <= ifc.pdn;
            hold_r   <= ifc.hold;
        end
    end

    assign data_pins         = pin_o_r;
    assign data_oe           = pin_oe_r;
    assign busy              = ifc.busy;
    assign sample_hold       = hold_r;
    assign low_power_state   = lowp_r;
    assign ref_enable        = ref_r;
    assign ref_buffer_enable = buf_r;

    // ************************
    // checks
    // ************************
    AST_BUS_HIZ: assert property (@(posedge clock) disable iff (!rst_b)
        !bus_en |=> pin_oe_r[15:12] == 4'h0 && pin_oe_r[`ACOC_PIN_SDO] == 1'b0)
        else $error("result pins driven while bus disabled");
    AST_BUS_EN: assert property (@(posedge clock) disable iff (!rst_b)
        bus_en |=> pin_oe_r[15:12] == 4'hf)
        else $error("bus not enabled with select and read low");
    AST_PAR_B11: assert property (@(posedge clock) disable iff (!rst_b)
        !ser_s |=> pin_o_r[`ACOC_PIN_ERR] == $past(ifc.result[11]))
        else $error("parallel bit 11 wrong");
    AST_UPPER: assert property (@(posedge clock) disable iff (!rst_b)
        ser_s |=> pin_o_r[15:12] == $past(ifc.result[15:12]))
        else $error("upper bits not driven in serial mode");
    AST_SYNC_HI: assert property (@(posedge clock) disable iff (!rst_b)
        (ser_s && ia_r && !inv_s) |=> pin_o_r[`ACOC_PIN_SYNC])
        else $error("frame sync not high during frame");
    AST_SYNC_LO: assert property (@(posedge clock) disable iff (!rst_b)
        (ser_s && ia_r && inv_s) |=> !pin_o_r[`ACOC_PIN_SYNC])
        else $error("frame sync not low during frame");
    AST_MSB: assert property (@(posedge clock) disable iff (!rst_b || rstp_s)
        i_start |=> ##1 pin_o_r[`ACOC_PIN_SDO] == $past(ifc.result[15], 2))
        else $error("first serial bit is not the top bit");
    AST_ERR_PULSE: assert property (@(posedge clock) disable iff (!rst_b || rstp_s)
        (err_set && ser_s && ext_s) |=> ##1 pin_o_r[`ACOC_PIN_ERR] [*4] ##1 !pin_o_r[`ACOC_PIN_ERR])
        else $error("incomplete read flag pulse wrong");
    AST_SCLK_DIR: assert property (@(posedge clock) disable iff (!rst_b)
        (ser_s && ext_s) |=> !pin_oe_r[`ACOC_PIN_SCLK])
        else $error("serial clock driven in external mode");
    AST_REF: assert property (@(posedge clock) disable iff (!rst_b)
        refd_s |=> !ref_enable)
        else $error("internal reference on while disabled");
    AST_BUF: assert property (@(posedge clock) disable iff (!rst_b)
        !bufd_s |=> ref_buffer_enable)
        else $error("buffer off while selected");
    CV_INT_FRAME: cover property (@(posedge clock) disable iff (!rst_b) $fell(ia_r) && sent_r);
    CV_ERR: cover property (@(posedge clock) disable iff (!rst_b) err_set);
    CV_PAR_READ: cover property (@(posedge clock) disable iff (!rst_b) !ser_s && bus_en && have_r);
endmodule

// ==== shared/acoc_map.svh ====
`ifndef ACOC_MAP_SVH
`define ACOC_MAP_SVH
`define ACOC_CLK_MHZ      200
`define ACOC_ACQ_NS       1000
`define ACOC_ACQ_CYC      ((`ACOC_ACQ_NS * `ACOC_CLK_MHZ + 999) / 1000)
`define ACOC_CONV_NS      8000
`define ACOC_CONV_CYC     ((`ACOC_CONV_NS * `ACOC_CLK_MHZ + 999) / 1000)
`define ACOC_SCLK_HALF_NS 50
`define ACOC_SCLK_HALF    ((`ACOC_SCLK_HALF_NS * `ACOC_CLK_MHZ) / 1000)
`define ACOC_ERR_CYC      3'h4
`define ACOC_WORD_BITS    5'h10
`define ACOC_PIN_SDO      8
`define ACOC_PIN_SCLK     9
`define ACOC_PIN_SYNC     10
`define ACOC_PIN_ERR      11
`define ACOC_RES_RST      16'h0000
`endif

// ==== shared/acoc_pkg.sv ====
package acoc_pkg;
    typedef enum logic [1:0] {
        ACOC_ACQ  = 2'b00,
        ACOC_ARM  = 2'b01,
        ACOC_CONV = 2'b10,
        ACOC_PDN  = 2'b11
    } acoc_cstate_t;
    typedef logic [15:0] acoc_word_t;
endpackage

// ==== shared/acoc_if.sv ====
`timescale 1ns/1ps
interface acoc_if;
    import acoc_pkg::*;
    logic       cnv_low;
    logic       cnv_fall;
    logic       pd;
    logic       abort;
    logic       busy;
    logic       hold;
    logic       pdn;
    logic       latched;
    acoc_word_t code;
    acoc_word_t result;
    logic       cs_n;
    logic       load_tgl;
    acoc_word_t load_word;
    logic       link_rst;
    logic       start_tgl;
    logic       done_tgl;
    logic       serial_data_out;
    modport conv (input cnv_low, cnv_fall, pd, abort, code,
                  output busy, hold, pdn, latched, result);
    modport link (input cs_n, load_tgl, load_word, link_rst,
                  output start_tgl, done_tgl, serial_data_out);
endinterface

// ==== hdl/acoc_conv.sv ====
`timescale 1ns/1ps
`include "acoc_map.svh"
module acoc_conv import acoc_pkg::*; #(
    parameter int ACQ_CYC  = `ACOC_ACQ_CYC,
    parameter int CONV_CYC = `ACOC_CONV_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // carrier
    acoc_if.conv     cv
);
    if (ACQ_CYC < 1 || ACQ_CYC > 65535 || CONV_CYC < 1 || CONV_CYC > 65535) begin : g_bad
        $error("acoc_conv: cycle counts out of range");
    end
    localparam logic [15:0] ACQ_LD  = 16'(ACQ_CYC - 1);
    localparam logic [15:0] CONV_LD = 16'(CONV_CYC - 1);

    acoc_cstate_t state_r, state_nxt;
    logic [15:0]  cnt_r, cnt_nxt;
    logic         busy_r, busy_nxt;
    logic         lat_r, lat_nxt;
    acoc_word_t   res_r, res_nxt;
    logic         go;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_r;
        lat_nxt   = 1'b0;
        res_nxt   = res_r;
        go        = 1'b0;
        case (state_r)
            ACOC_ACQ: begin
                if (cnt_r != 16'h0000) begin
                    cnt_nxt = cnt_r - 16'h0001;
                end else if (cv.pd) begin
                    state_nxt = ACOC_PDN;
                end else if (cv.cnv_low) begin
                    go = 1'b1;
                end else begin
                    state_nxt = ACOC_ARM;
                end
            end
            ACOC_ARM: begin
                if (cv.pd) begin
                    state_nxt = ACOC_PDN;
                end else if (cv.cnv_fall) begin
                    go = 1'b1;
                end
            end
            ACOC_CONV: begin
                if (cnt_r != 16'h0000) begin
                    cnt_nxt = cnt_r - 16'h0001;
                end else begin
                    // result latched in the same edge busy falls
                    res_nxt   = cv.code;
                    lat_nxt   = 1'b1;
                    busy_nxt  = 1'b0;
                    state_nxt = ACOC_ACQ;
                    cnt_nxt   = ACQ_LD;
                end
            end
            ACOC_PDN: begin
                if (!cv.pd) begin
                    state_nxt = ACOC_ACQ;
                    cnt_nxt   = ACQ_LD;
                end
            end
            default: begin
                state_nxt = ACOC_ACQ;
                cnt_nxt   = ACQ_LD;
            end
        endcase
        if (go) begin
            state_nxt = ACOC_CONV;
            cnt_nxt   = CONV_LD;
            busy_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || cv.abort) begin
            state_r <= ACOC_ACQ;
            cnt_r   <= ACQ_LD;
            busy_r  <= 1'b0;
            lat_r   <= 1'b0;
            res_r   <= `ACOC_RES_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
            lat_r   <= lat_nxt;
            res_r   <= res_nxt;
        end
    end

    assign cv.busy    = busy_r;
    assign cv.hold    = (state_r == ACOC_CONV);
    assign cv.pdn     = (state_r == ACOC_PDN);
    assign cv.latched = lat_r;
    assign cv.result  = res_r;

    AST_BUSY_RISE: assert property (@(posedge clock) disable iff (!rst_b || cv.abort)
        (state_r == ACOC_ACQ && cnt_r == 16'h0000 && !cv.pd && cv.cnv_low) |=> busy_r && cv.hold)
        else $error("busy did not rise on start");
    AST_WAIT_EDGE: assert property (@(posedge clock) disable iff (!rst_b || cv.abort)
        (state_r == ACOC_ARM && !cv.cnv_fall) |=> !busy_r)
        else $error("conversion began without a falling start edge");
    AST_PD_INHIBIT: assert property (@(posedge clock) disable iff (!rst_b || cv.abort)
        (state_r == ACOC_PDN && cv.pd) |=> !busy_r && state_r == ACOC_PDN)
        else $error("conversion while powered down");
    AST_LATCH: assert property (@(posedge clock) disable iff (!rst_b || cv.abort)
        $fell(busy_r) |-> lat_r && res_r == $past(cv.code))
        else $error("busy fell without latching the result");
    AST_ABORT: assert property (@(posedge clock) disable iff (!rst_b)
        cv.abort |=> !busy_r && state_r == ACOC_ACQ)
        else $error("reset input did not abort");
    CV_CONV: cover property (@(posedge clock) disable iff (!rst_b) $fell(busy_r));
endmodule

// ==== hdl/acoc_link.sv ====
`timescale 1ns/1ps
`include "acoc_map.svh"
module acoc_link import acoc_pkg::*; (
    // link clock
    input wire logic sclk_ext,
    // carrier
    acoc_if.link     lk
);
    logic       rs1_r, rs2_r;
    logic       ld1_r, ld2_r, ld3_r;
    logic       cs1_r, cs2_r;
    acoc_word_t sh_r, sh_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic       st_r, st_nxt;
    logic       dn_r, dn_nxt;
    logic       sdo_r, sdo_nxt;

    always_comb begin
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        st_nxt  = st_r;
        dn_nxt  = dn_r;
        sdo_nxt = sdo_r;
        if (ld3_r != ld2_r) begin
            // a new result drops whatever was half read
            sh_nxt  = lk.load_word;
            cnt_nxt = `ACOC_WORD_BITS;
        end else if (!cs2_r && cnt_r != 5'h00) begin
            sdo_nxt = sh_r[15];
            sh_nxt  = {sh_r[14:0], 1'b0};
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == `ACOC_WORD_BITS) begin
                st_nxt = ~st_r;
            end
            if (cnt_r == 5'h01) begin
                dn_nxt = ~dn_r;
            end
        end
    end

    always_ff @(posedge sclk_ext) begin
        rs1_r <= lk.link_rst;
        rs2_r <= rs1_r;
        ld1_r <= lk.load_tgl;
        ld2_r <= ld1_r;
        ld3_r <= ld2_r;
        cs1_r <= lk.cs_n;
        cs2_r <= cs1_r;
        if (rs2_r) begin
            sh_r  <= `ACOC_RES_RST;
            cnt_r <= 5'h00;
            st_r  <= 1'b0;
            dn_r  <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_nxt;
            st_r  <= st_nxt;
            dn_r  <= dn_nxt;
            sdo_r <= sdo_nxt;
        end
    end

    assign lk.start_tgl = st_r;
    assign lk.done_tgl  = dn_r;
    assign lk.serial_data_out     = sdo_r;

    AST_CS_GATE: assert property (@(posedge sclk_ext) disable iff (rs2_r)
        (cs2_r && ld3_r == ld2_r) |=> $stable(cnt_r) && $stable(sh_r))
        else $error("external clock shifted while deselected");
endmodule

// ==== test/acoc_host.sv ====
`timescale 1ns/1ps
// ****************
// serial host side
// ****************
module acoc_host (
    // pins seen by the host
    input wire logic        clock,
    input wire logic [15:0] data_o,
    input wire logic        polarity,
    input wire logic        clr,
    // captured word
    output logic     [15:0] word_r,
    output logic     [4:0]  bits_r
);
    logic sclk_q;
    // shifts on the rising serial clock, only inside the frame
    always @(posedge clock) begin
        sclk_q <= data_o[9];
        if (clr) begin
            bits_r <= 5'h00;
        end else if (data_o[9] && !sclk_q && (data_o[10] != polarity)) begin
            word_r <= {word_r[14:0], data_o[8]};
            bits_r <= bits_r + 5'h01;
        end
    end
endmodule

// ==== test/adc_conversion_output_control_bench.sv ====
`timescale 1ns/1ps
module adc_conversion_output_control_bench;
    import acoc_pkg::*;
    logic       clock, rst_b, sclk_ext, cnv_n, cs_n, rd_n, rst_pin, lpr, spsel, csel, fsp, ird, rbd, clr;
    acoc_word_t code, adc_code, data_o, data_oe, word;
    logic       busy, sample_hold, low_power_state, ref_enable, ref_buffer_enable;
    logic [4:0] nbits;
    logic [31:0] seed;
    int         num_errors, checks, cycles, hi;
    acoc_top #(.ACQ_CYC(4), .CONV_CYC(20), .SCLK_HALF(2)) i_acoc_top (.clock(clock), .rst_b(rst_b),
        .sclk_ext(sclk_ext), .conversion_start_n(cnv_n), .cs_n(cs_n), .rd_n(rd_n), .reset_pin(rst_pin),
        .low_power_request(lpr), .serial_parallel_select(spsel), .clock_source_select(csel),
        .frame_sync_polarity(fsp), .internal_ref_disable(ird), .ref_buffer_disable(rbd), .adc_code(adc_code),
        .data_pins(data_o), .data_oe(data_oe), .busy(busy), .sample_hold(sample_hold),
        .low_power_state(low_power_state), .ref_enable(ref_enable), .ref_buffer_enable(ref_buffer_enable));
    acoc_host i_acoc_host (.clock(clock), .data_o(data_o), .polarity(fsp), .clr(clr), .word_r(word),
        .bits_r(nbits));
    // ***********
    // bench tools
    // ***********
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 200) begin
            cyc(1);
            n++;
        end
        check("busy", {15'h0000, lvl}, {15'h0000, busy});
    endtask
    task automatic convert(input acoc_word_t c);
        @(posedge clock);
        adc_code <= c;
        cnv_n <= 1'b0;
        wait_busy(1'b1);
        @(posedge clock);
        cnv_n <= 1'b1;
        cyc(2);
        check("hold", 16'h0001, {15'h0000, sample_hold});
        wait_busy(1'b0);
    endtask
    // off-grid phase keeps link edges off clock edges only when started right after cyc
    task automatic sclk(input int n);
        #2;
        repeat (n) begin
            #80 sclk_ext = 1'b1;
            #80 sclk_ext = 1'b0;
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    // **********
    // test steps
    // **********
    initial begin
        {rst_b, sclk_ext, rst_pin, lpr, spsel, csel, fsp, ird, rbd, clr} = 10'h000;
        {cnv_n, cs_n, rd_n} = 3'h7;
        adc_code = 16'h0000;
        seed = 32'ha267;
        {num_errors, checks} = 0;
        cyc(10);
        // link flops clear only while their clock runs, so hold the reset pin meanwhile
        {rst_b, rst_pin} <= 2'h3;
        sclk(4);
        @(posedge clock);
        rst_pin <= 1'b0;
        cyc(4);
        check("oe_rst", 16'h0000, data_oe);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {rbd, ird} <= i[1:0];
            cyc(6);
            check("ref", {14'h0000, ~i[1:0]}, {14'h0000, ref_buffer_enable, ref_enable});
        end
        $display("reference tests done");
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            code = (k == 0) ? 16'h0800 : seed[15:0];
            @(posedge clock);
            {spsel, fsp, clr} <= {k[0], k[1], 1'b1};
            convert(code);
            @(posedge clock);
            {cs_n, rd_n, clr} <= 3'h0;
            cyc(90);
            if (k[0]) begin
                check("word", code, word);
                check("bits", 16'h0010, {11'h000, nbits});
                check("oe_hi", 16'hf000, data_oe & 16'hf000);
            end else begin
                check("par", code, data_o);
                check("oe_par", 16'hffff, data_oe);
            end
            @(posedge clock);
            {cs_n, rd_n, clr} <= 3'h7;
            cyc(6);
            check("oe_off", 16'h0000, data_oe & (k[0] ? 16'hf000 : 16'hffff));
            if (k[0]) check("sync_idle", {15'h0000, fsp}, {15'h0000, data_o[10]});
            $display("read test %0d done", k);
        end
        @(posedge clock);
        cnv_n <= 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        @(posedge clock);
        cnv_n <= 1'b1;
        cyc(30);
        check("no_edge", 16'h0000, {15'h0000, busy});
        cnv_n <= 1'b0;
        wait_busy(1'b1);
        rst_pin <= 1'b1;
        cyc(5);
        check("abort", 16'h0000, {15'h0000, busy});
        {rst_pin, cnv_n} <= 2'h1;
        cyc(10);
        $display("start and abort tests done");
        {spsel, csel} <= 2'h3;
        convert(16'ha543);
        sclk(4);
        {cs_n, rd_n} <= 2'h0;
        sclk(8);
        // six gated edges leave bit 10 out; a leaky gate would show bit 7
        check("sdo_ext", 16'h0001, {15'h0000, data_o[8]});
        convert(16'(xs(seed)));
        hi = 0;
        repeat (12) begin
            cyc(1);
            hi += (data_o[11] === 1'b1 && data_oe[11] === 1'b1);
        end
        check("err_pulse", 16'h0004, hi[15:0]);
        {cs_n, rd_n} <= 2'h3;
        @(posedge clock);
        cnv_n <= 1'b0;
        wait_busy(1'b1);
        {lpr, cnv_n} <= 2'h3;
        wait_busy(1'b0);
        cyc(20);
        check("pdn", 16'h0001, {15'h0000, low_power_state});
        cnv_n <= 1'b0;
        cyc(30);
        check("pdn_idle", 16'h0000, {15'h0000, busy});
        $display("error flag and power-down tests done");
        test_done();
    end
endmodule
